// ---- common/flpc_pkg.sv ----
// ==========================================
// Constants for the fastlock and counter control block.
package flpc_pkg;
   localparam int WORD_W = 24;
   // Sixth configuration word fields.
   localparam int SLIP_HI = 23;
   localparam int SLIP_LO = 22;
   localparam int PUMP_HI = 21;
   localparam int PUMP_LO = 18;
   localparam int TOC_HI = 17;
   localparam int TOC_LO = 4;
   localparam int TOC_W = 14;
   // Seventh configuration word bits.
   localparam int QUARTER_BIT = 13;
   localparam int AUX_CLEAR_BIT = 7;
   localparam int MAIN_CLEAR_BIT = 6;
   localparam int AUX_FLOAT_BIT = 5;
   localparam int MAIN_FLOAT_BIT = 4;
   // Timeout codes with special meaning.
   localparam logic [13:0] TOC_FLOAT = 14'h0000;
   localparam logic [13:0] TOC_MANUAL = 14'h0001;
   localparam logic [13:0] TOC_LOW = 14'h0002;
   localparam logic [13:0] TOC_HIGH = 14'h0003;
   localparam logic [13:0] TOC_TIMED_MIN = 14'h0004;
   localparam int CNT_W = 15;
   localparam logic [14:0] CNT_ONE = 15'h0001;
   localparam logic [4:0] MULT_ONE = 5'h01;
   // Sample-rate reduction codes and divide ratios.
   localparam logic [1:0] SLIP_OFF = 2'h0;
   localparam logic [1:0] SLIP_HALF = 2'h1;
   localparam logic [1:0] SLIP_QUARTER = 2'h2;
   localparam logic [4:0] RATIO_1 = 5'h01;
   localparam logic [4:0] RATIO_2 = 5'h02;
   localparam logic [4:0] RATIO_4 = 5'h04;
   localparam logic [4:0] RATIO_16 = 5'h10;
   localparam logic [1:0] LD_DIV_LAST = 2'h3;
   typedef enum logic [1:0] {
      FLPC_IDLE = 2'b00,
      FLPC_TIMED = 2'b01,
      FLPC_MANUAL = 2'b10
   } flpc_state_e;
endpackage : flpc_pkg

// ---- verilog/flpc_control.sv ----
`timescale 1ns/1ps
module flpc_control (
   input wire logic clock,
   input wire logic rstn,
   input wire logic power_up,
   input wire logic [23:0] fast_word,
   input wire logic fast_word_load,
   input wire logic [23:0] lock_detect_and_counter_control,
   input wire logic control_load,
   input wire logic freq_word_load,
   input wire logic main_compare,
   input wire logic aux_compare,
   output logic main_fast_output_pin,
   output logic main_fast_output_pin_oe,
   output logic fast_active,
   output logic [4:0] main_pump_mult,
   output logic [4:0] slip_ratio,
   output logic main_ld_compare,
   output logic aux_ld_compare,
   output logic main_counter_clear,
   output logic aux_counter_clear,
   output logic main_pump_float,
   output logic aux_pump_float
);
   // ==========================================
   // Stored fields.
   logic [1:0] slip_reduce_select;
   logic [3:0] main_fast_pump_current;
   logic [13:0] main_fast_timeout_code;
   logic lock_detect_quarter;
   logic main_clear_bit;
   logic aux_clear_bit;
   logic main_float_bit;
   logic aux_float_bit;
   logic power_up_q;
   logic [14:0] fast_count;
   logic [1:0] ld_div;
   flpc_pkg::flpc_state_e state;
   flpc_pkg::flpc_state_e next_state;
   logic [14:0] next_fast_count;

   function automatic logic [4:0] slip_factor(input logic [1:0] code);
      case (code)
         flpc_pkg::SLIP_OFF: slip_factor = flpc_pkg::RATIO_1;
         flpc_pkg::SLIP_HALF: slip_factor = flpc_pkg::RATIO_2;
         flpc_pkg::SLIP_QUARTER: slip_factor = flpc_pkg::RATIO_4;
         default: slip_factor = flpc_pkg::RATIO_16;
      endcase
   endfunction : slip_factor

   // ==========================================
   // Decoding.
   wire power_edge = power_up & ~power_up_q;
   wire timed_code = main_fast_timeout_code >= flpc_pkg::TOC_TIMED_MIN;
   wire manual_code = main_fast_timeout_code == flpc_pkg::TOC_MANUAL;
   wire [14:0] fast_len = {main_fast_timeout_code, 1'b0};
   wire in_fast = state != flpc_pkg::FLPC_IDLE;
   wire next_pin = (state == flpc_pkg::FLPC_TIMED) ? 1'b1 :
                   (main_fast_timeout_code == flpc_pkg::TOC_HIGH);
   wire next_oe = main_fast_timeout_code != flpc_pkg::TOC_FLOAT;
   wire [4:0] next_mult = {1'b0, main_fast_pump_current} + flpc_pkg::MULT_ONE;

   // ==========================================
   // Configuration capture.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         slip_reduce_select <= flpc_pkg::SLIP_OFF;
         main_fast_pump_current <= 4'h0;
         main_fast_timeout_code <= flpc_pkg::TOC_FLOAT;
      end else if (fast_word_load) begin
         slip_reduce_select <= fast_word[flpc_pkg::SLIP_HI:flpc_pkg::SLIP_LO];
         main_fast_pump_current <= fast_word[flpc_pkg::PUMP_HI:flpc_pkg::PUMP_LO];
         main_fast_timeout_code <= fast_word[flpc_pkg::TOC_HI:flpc_pkg::TOC_LO];
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lock_detect_quarter <= 1'b0;
         main_clear_bit <= 1'b0;
         aux_clear_bit <= 1'b0;
         main_float_bit <= 1'b0;
         aux_float_bit <= 1'b0;
      end else if (control_load) begin
         lock_detect_quarter <= lock_detect_and_counter_control[flpc_pkg::QUARTER_BIT];
         main_clear_bit <= lock_detect_and_counter_control[flpc_pkg::MAIN_CLEAR_BIT];
         aux_clear_bit <= lock_detect_and_counter_control[flpc_pkg::AUX_CLEAR_BIT];
         main_float_bit <= lock_detect_and_counter_control[flpc_pkg::MAIN_FLOAT_BIT];
         aux_float_bit <= lock_detect_and_counter_control[flpc_pkg::AUX_FLOAT_BIT];
      end
   end

   // ==========================================
   // Fastlock sequencing.
   always_comb begin
      next_state = state;
      next_fast_count = fast_count;
      if (fast_word_load || freq_word_load) begin
         next_state = flpc_pkg::FLPC_IDLE;
         next_fast_count = '0;
      end else begin
         case (state)
            flpc_pkg::FLPC_IDLE: begin
               if (manual_code) begin
                  next_state = flpc_pkg::FLPC_MANUAL;
               end
            end
            flpc_pkg::FLPC_MANUAL: begin
               if (!manual_code) begin
                  next_state = flpc_pkg::FLPC_IDLE;
               end
            end
            flpc_pkg::FLPC_TIMED: begin
               if (main_compare) begin
                  next_fast_count = fast_count - flpc_pkg::CNT_ONE;
                  if (fast_count == flpc_pkg::CNT_ONE) begin
                     next_state = flpc_pkg::FLPC_IDLE;
                  end
               end
            end
            default: next_state = flpc_pkg::FLPC_IDLE;
         endcase
      end
      if (freq_word_load && timed_code) begin
         next_state = flpc_pkg::FLPC_TIMED;
         next_fast_count = fast_len;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state <= flpc_pkg::FLPC_IDLE;
         fast_count <= '0;
         power_up_q <= 1'b0;
         ld_div <= 2'h0;
      end else begin
         state <= next_state;
         fast_count <= next_fast_count;
         power_up_q <= power_up;
         if (main_compare) begin
            ld_div <= ld_div + 2'h1;
         end
      end
   end

   // ==========================================
   // Registered outputs.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         main_fast_output_pin <= 1'b0;
         main_fast_output_pin_oe <= 1'b0;
         fast_active <= 1'b0;
         main_pump_mult <= flpc_pkg::MULT_ONE;
         slip_ratio <= flpc_pkg::RATIO_1;
         main_ld_compare <= 1'b0;
         aux_ld_compare <= 1'b0;
         main_counter_clear <= 1'b1;
         aux_counter_clear <= 1'b1;
         main_pump_float <= 1'b1;
         aux_pump_float <= 1'b1;
      end else begin
         main_fast_output_pin <= next_pin;
         main_fast_output_pin_oe <= next_oe;
         fast_active <= in_fast;
         main_pump_mult <= in_fast ? next_mult : flpc_pkg::MULT_ONE;
         slip_ratio <= slip_factor(slip_reduce_select);
         main_ld_compare <= lock_detect_quarter ?
                            (main_compare && ld_div == flpc_pkg::LD_DIV_LAST) :
                            main_compare;
         aux_ld_compare <= aux_compare;
         main_counter_clear <= main_clear_bit | power_edge;
         aux_counter_clear <= aux_clear_bit | power_edge;
         main_pump_float <= main_clear_bit | main_float_bit | power_edge;
         aux_pump_float <= aux_clear_bit | aux_float_bit | power_edge;
      end
   end

   // ==========================================
   // Checks.
   a_manual_pin_low: assert property (@(posedge clock) disable iff (!rstn)
      state == flpc_pkg::FLPC_MANUAL |=> !main_fast_output_pin && fast_active)
      else $error("manual fastlock pin not low");
   a_float_code_oe: assert property (@(posedge clock) disable iff (!rstn)
      main_fast_timeout_code == flpc_pkg::TOC_FLOAT && !fast_word_load
      |=> !main_fast_output_pin_oe)
      else $error("pin driven with float code");
   a_timed_start: assert property (@(posedge clock) disable iff (!rstn)
      freq_word_load && timed_code |=> state == flpc_pkg::FLPC_TIMED
      && fast_count == {$past(main_fast_timeout_code), 1'b0})
      else $error("timed fastlock count wrong");
   sequence s_timed_last;
      state == flpc_pkg::FLPC_TIMED && main_compare && fast_count == flpc_pkg::CNT_ONE
      && !fast_word_load && !freq_word_load;
   endsequence : s_timed_last
   sequence s_back_to_steady;
      state == flpc_pkg::FLPC_IDLE ##1 main_pump_mult == flpc_pkg::MULT_ONE;
   endsequence : s_back_to_steady
   a_expire_idle: assert property (@(posedge clock) disable iff (!rstn)
      s_timed_last |=> s_back_to_steady)
      else $error("fastlock did not expire");
   a_pump_mult: assert property (@(posedge clock) disable iff (!rstn)
      in_fast |=> main_pump_mult == $past(next_mult))
      else $error("fastlock multiplier wrong");
   a_slip_ratio: assert property (@(posedge clock) disable iff (!rstn)
      slip_reduce_select == flpc_pkg::SLIP_OFF |=> slip_ratio == flpc_pkg::RATIO_1)
      else $error("slip ratio wrong");
   a_quarter_rate: assert property (@(posedge clock) disable iff (!rstn)
      lock_detect_quarter && main_compare && ld_div != flpc_pkg::LD_DIV_LAST
      |=> !main_ld_compare)
      else $error("lock detect not divided");
   a_main_clear: assert property (@(posedge clock) disable iff (!rstn)
      main_clear_bit |=> main_counter_clear && main_pump_float)
      else $error("main clear not applied");
   a_aux_clear: assert property (@(posedge clock) disable iff (!rstn)
      aux_clear_bit |=> aux_counter_clear && aux_pump_float)
      else $error("aux clear not applied");
   a_aux_float_only: assert property (@(posedge clock) disable iff (!rstn)
      aux_float_bit && !aux_clear_bit && !power_edge |=> aux_pump_float && !aux_counter_clear)
      else $error("aux float wrong");
   a_main_float_only: assert property (@(posedge clock) disable iff (!rstn)
      main_float_bit && !main_clear_bit && !power_edge
      |=> main_pump_float && !main_counter_clear)
      else $error("main float wrong");
   a_power_clear: assert property (@(posedge clock) disable iff (!rstn)
      power_edge |=> main_counter_clear && aux_counter_clear)
      else $error("power-up clear missing");
endmodule : flpc_control

// ---- test/flpc_host.sv ----
`timescale 1ns/1ps
// ==========================================
// Host controller model that writes the configuration words.
module flpc_host (
   input wire logic clock,
   output logic [23:0] fast_word,
   output logic fast_word_load,
   output logic [23:0] ctrl_word,
   output logic ctrl_load,
   output logic freq_load
);
   initial begin
      fast_word = 24'h000000;
      fast_word_load = 1'b0;
      ctrl_word = 24'h000000;
      ctrl_load = 1'b0;
      freq_load = 1'b0;
   end
   // Words are inverted once the load pulse is over.
   task automatic send_fast(input logic [23:0] w);
      @(posedge clock);
      fast_word <= w;
      fast_word_load <= 1'b1;
      @(posedge clock);
      fast_word_load <= 1'b0;
      fast_word <= ~w;
   endtask : send_fast
   // Fixed ones are always sent; other fixed bits stay zero.
   task automatic send_ctrl(input logic [23:0] w);
      @(posedge clock);
      ctrl_word <= (w & 24'h0020f0) | 24'h00090f;
      ctrl_load <= 1'b1;
      @(posedge clock);
      ctrl_load <= 1'b0;
      ctrl_word <= ~w;
   endtask : send_ctrl
   task automatic tune;
      @(posedge clock);
      freq_load <= 1'b1;
      @(posedge clock);
      freq_load <= 1'b0;
   endtask : tune
endmodule : flpc_host

// ---- test/flpc_control_tb_top.sv ----
`timescale 1ns/1ps
// ==========================================
// Self-checking bench for the fastlock and counter control block.
module flpc_control_tb_top;
   logic clock, rstn, power_up, main_compare, aux_compare, fw_load, cw_load, fq_load;
   logic [23:0] fw, cw;
   logic pin, pin_oe, fast_active, main_ld, aux_ld, m_clr, a_clr, m_flt, a_flt;
   logic [4:0] mult, ratio;
   logic [13:0] toc;
   logic [3:0] cpf, bits;
   int error_cnt = 0;
   int n_compared = 0;
   int seed = 27227;
   int n_mld = 0;
   int n_ald = 0;
   flpc_control flpc_control_inst (.clock(clock), .rstn(rstn), .power_up(power_up),
      .fast_word(fw), .fast_word_load(fw_load), .lock_detect_and_counter_control(cw),
      .control_load(cw_load), .freq_word_load(fq_load), .main_compare(main_compare),
      .aux_compare(aux_compare), .main_fast_output_pin(pin), .main_fast_output_pin_oe(pin_oe),
      .fast_active(fast_active), .main_pump_mult(mult), .slip_ratio(ratio),
      .main_ld_compare(main_ld), .aux_ld_compare(aux_ld), .main_counter_clear(m_clr),
      .aux_counter_clear(a_clr), .main_pump_float(m_flt), .aux_pump_float(a_flt));
   flpc_host flpc_host_inst (.clock(clock), .fast_word(fw), .fast_word_load(fw_load),
      .ctrl_word(cw), .ctrl_load(cw_load), .freq_load(fq_load));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock) begin
      n_mld <= n_mld + int'(main_ld === 1'b1);
      n_ald <= n_ald + int'(aux_ld === 1'b1);
   end
   function automatic logic [4:0] exp_ratio(input logic [1:0] c);
      return (c == 2'h0) ? 5'h01 : (c == 2'h1) ? 5'h02 : (c == 2'h2) ? 5'h04 : 5'h10;
   endfunction : exp_ratio
   task automatic chk1(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t bit got %b want %b", $time, got, exp);
      end
   endtask : chk1
   task automatic chk5(input logic [4:0] got, input logic [4:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t value got %0d want %0d", $time, got, exp);
      end
   endtask : chk5
   task automatic wrap_up;
      $display("mismatches %0d compares %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up
   task automatic settle;
      repeat (3) @(posedge clock);
      #1;
   endtask : settle
   task automatic pulse(input int n, input logic m, input logic a);
      repeat (n) begin
         @(posedge clock);
         main_compare <= m;
         aux_compare <= a;
         @(posedge clock);
         main_compare <= 1'b0;
         aux_compare <= 1'b0;
      end
   endtask : pulse
   initial begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      wrap_up();
   end
   initial begin
      rstn = 1'b0;
      power_up = 1'b0;
      main_compare = 1'b0;
      aux_compare = 1'b0;
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      settle();
      chk1(m_clr | a_clr | m_flt | a_flt, 1'b0);
      @(posedge clock);
      power_up <= 1'b1;
      for (int i = 0; i < 8 && m_clr !== 1'b1; i++) @(posedge clock) #1;
      chk1(m_clr & a_clr, 1'b1);
      for (int i = 0; i < 9; i++) begin
         bits = (i == 8) ? 4'h0 : (i == 7) ? 4'hf : 4'($random(seed));
         flpc_host_inst.send_ctrl({16'h0000, bits, 4'h0});
         settle();
         chk1(a_clr, bits[3]);
         chk1(m_clr, bits[2]);
         chk1(a_flt, bits[3] | bits[1]);
         chk1(m_flt, bits[2] | bits[0]);
      end
      for (int q = 0; q < 2; q++) begin
         flpc_host_inst.send_ctrl(q == 1 ? 24'h002000 : 24'h000000);
         settle();
         n_mld = 0;
         n_ald = 0;
         pulse(8, 1'b1, 1'b1);
         settle();
         chk5(5'(n_mld), q == 1 ? 5'h02 : 5'h08);
         chk5(5'(n_ald), 5'h08);
      end
      for (int c = 0; c < 4; c++) begin
         cpf = 4'($random(seed));
         flpc_host_inst.send_fast({2'(c), cpf, 14'(c), 4'hd});
         settle();
         chk5(ratio, exp_ratio(2'(c)));
         chk1(pin_oe, c != 0);
         chk1(pin, c == 3);
         chk1(fast_active, c == 1);
         chk5(mult, c == 1 ? {1'b0, cpf} + 5'h01 : 5'h01);
      end
      for (int k = 0; k < 3; k++) begin
         toc = (k == 0) ? 14'h0004 : 14'h0004 + 14'(4'($random(seed)));
         cpf = (k == 2) ? 4'hf : 4'($random(seed));
         flpc_host_inst.send_fast({2'h0, cpf, toc, 4'hd});
         flpc_host_inst.tune();
         settle();
         chk1(fast_active & pin & pin_oe, 1'b1);
         chk5(mult, {1'b0, cpf} + 5'h01);
         pulse(2 * toc - 1, 1'b1, 1'b0);
         settle();
         chk1(fast_active, 1'b1);
         if (k == 1) begin
            flpc_host_inst.tune();
            pulse(2 * toc - 1, 1'b1, 1'b0);
            settle();
            chk1(fast_active, 1'b1);
         end
         pulse(1, 1'b1, 1'b0);
         settle();
         chk1(fast_active | pin, 1'b0);
         chk5(mult, 5'h01);
      end
      wrap_up();
   end
endmodule : flpc_control_tb_top
